// ---- src/stacal_defines.svh ----
// Summary of operation
// - neutral capture accepted only strictly between min and max neutral limits, both sensors
// - flag calibration error when captured neutral lies outside the neutral window
// - pick higher of left/right, both spans to neutral must reach minimum span
// - flag calibration error when captured span is below the minimum span
// - right edge accepted within min..max dead-band limits inclusive, stored as right value
// - left edge accepted within -max..-min limits inclusive, stored as left value
// - start refused until wheel armed; wheel grab disengages running calibration
// - spool calibration status code is reported in status byte 4
// - status 0x21 while wheel not yet armed
// - status 0x22 while wheel is being operated into steering active
// - status 0x23 and seconds counter once operation stops; timeout closes window
// - sweep timing only inside the sweep half range, 5..400, default 25; the checker stores this register but never uses it
// - wheels move over sweep plus add-on range, 5..400, timing only inside sweep; the add-on register is stored but never used
// - attempt too slow when sweep time exceeds max time, default 110
// - attempt too fast when sweep time is below min time, default 60
// - separate attempt vector per side, size 1..10, default 7; sizes above 10 act as 10, a size of 0 is not raised to 1
// - side calibrated when configured count of vector entries hold equal values
// - too slow adds step percent to set-point, too fast subtracts it
// - separate neutral window for CAN sensor, defaults 4500 and 500 mV
// - separate minimum span for CAN sensor, default 0 mV
// - attempt vector is first-in first-out, oldest dropped when full
`ifndef STACAL_DEFINES_SVH
`define STACAL_DEFINES_SVH
`define STACAL_OFF_SWEEP_HALF 12'h000
`define STACAL_OFF_MAX_TIME 12'h004
`define STACAL_OFF_MIN_TIME 12'h008
`define STACAL_OFF_VEC_SIZE 12'h00C
`define STACAL_OFF_MIN_EQUAL 12'h010
`define STACAL_OFF_SWEEP_ADDON 12'h014
`define STACAL_OFF_STEP_PCT 12'h018
`define STACAL_OFF_CAN_NMAX 12'h01C
`define STACAL_OFF_CAN_SPAN 12'h020
`define STACAL_OFF_CAN_NMIN 12'h024
`define STACAL_OFF_ANA_NMAX 12'h028
`define STACAL_OFF_ANA_SPAN 12'h02C
`define STACAL_OFF_ANA_NMIN 12'h030
`define STACAL_OFF_DB_MAX 12'h034
`define STACAL_OFF_DB_MIN 12'h038
`define STACAL_OFF_ACT_TMO 12'h03C
`define STACAL_OFF_INIT_SP 12'h040
`define STACAL_OFF_STATUS 12'h044
`define STACAL_OFF_DEADBAND 12'h048
`define STACAL_OFF_SETPOINT 12'h04C
`define STACAL_RST_SWEEP_HALF 16'h0019
`define STACAL_RST_MAX_TIME 16'h006E
`define STACAL_RST_MIN_TIME 16'h003C
`define STACAL_RST_VEC_SIZE 8'h07
`define STACAL_RST_MIN_EQUAL 8'h05
`define STACAL_RST_SWEEP_ADDON 16'h0019
`define STACAL_RST_STEP_PCT 8'h0A
`define STACAL_RST_CAN_NMAX 16'h1194
`define STACAL_RST_CAN_SPAN 16'h0000
`define STACAL_RST_CAN_NMIN 16'h01F4
`define STACAL_RST_ANA_NMAX 16'h1194
`define STACAL_RST_ANA_SPAN 16'h0000
`define STACAL_RST_ANA_NMIN 16'h01F4
`define STACAL_RST_DB_MAX 16'h012C
`define STACAL_RST_DB_MIN 16'h0000
`define STACAL_RST_ACT_TMO 8'h14
`define STACAL_RST_INIT_SP 16'h007D
`define STACAL_CODE_INACTIVE 8'h21
`define STACAL_CODE_ARMING 8'h22
`define STACAL_CODE_ARMED 8'h23
`define STACAL_CODE_RUNNING 8'h24
`define STACAL_VEC_MAX 10
`define STACAL_CLK_HZ 125000000
`define STACAL_SECOND_S 1
`define STACAL_SECOND_CYCLES (`STACAL_CLK_HZ * `STACAL_SECOND_S)
`endif

// ---- src/stacal_pkg.sv ----
package stacal_pkg;
    typedef enum logic [1:0] {
        STACAL_IDLE = 2'b00,
        STACAL_ARMING = 2'b01,
        STACAL_ARMED = 2'b10,
        STACAL_RUN = 2'b11
    } stacal_state_type;
    // one set of wheel-angle sensor captures
    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
        logic [15:0] neutral;
    } stacal_capture_type;
    // one finished sweep attempt on one side
    typedef struct packed {
        logic side_left;
        logic [15:0] sweep_time;
        logic [15:0] db_edge;
    } stacal_attempt_type;
endpackage

// ---- src/stacal_checker.sv ----
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "stacal_defines.svh"
module stacal_checker #(
    parameter int SECOND_CYCLES = `STACAL_SECOND_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_valid,
    input wire logic capture_is_can,
    input wire stacal_pkg::stacal_capture_type capture,
    output logic capture_done,
    output logic neutral_error,
    output logic span_error,
    input wire logic attempt_valid,
    input wire stacal_pkg::stacal_attempt_type attempt,
    output logic [15:0] left_deadband_value,
    output logic [15:0] right_deadband_value,
    output logic left_done,
    output logic right_done,
    output logic [15:0] spool_setpoint,
    input wire logic steering_active,
    input wire logic wheel_grab,
    input wire logic start_request,
    output logic calib_running,
    output logic [7:0] status_byte4
);
    import stacal_pkg::*;

    logic [15:0] sweep_half_range_reg, max_sweep_time_reg, min_sweep_time_reg;
    logic [7:0] attempt_vector_size_reg, min_equal_attempts_reg, setpoint_step_percent_reg;
    logic [15:0] sweep_addon_range_reg;
    logic [15:0] can_sensor_neutral_max_reg, can_sensor_min_span_reg, can_sensor_neutral_min_reg;
    logic [15:0] analog_neutral_max_reg, analog_min_span_reg, analog_neutral_min_reg;
    logic [15:0] deadband_limit_max_reg, deadband_limit_min_reg, initial_spool_setpoint_reg;
    logic [7:0] activation_timeout_reg;
    logic [31:0] rd_next;
    logic bad_addr;
    logic wr_en, rd_en;

    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    // read mux; unmapped offsets answer with an error and zero data
    always_comb begin
        rd_next = 32'h0000_0000;
        bad_addr = 1'b0;
        case (paddr)
            `STACAL_OFF_SWEEP_HALF: rd_next = {16'h0000, sweep_half_range_reg};
            `STACAL_OFF_MAX_TIME: rd_next = {16'h0000, max_sweep_time_reg};
            `STACAL_OFF_MIN_TIME: rd_next = {16'h0000, min_sweep_time_reg};
            `STACAL_OFF_VEC_SIZE: rd_next = {24'h000000, attempt_vector_size_reg};
            `STACAL_OFF_MIN_EQUAL: rd_next = {24'h000000, min_equal_attempts_reg};
            `STACAL_OFF_SWEEP_ADDON: rd_next = {16'h0000, sweep_addon_range_reg};
            `STACAL_OFF_STEP_PCT: rd_next = {24'h000000, setpoint_step_percent_reg};
            `STACAL_OFF_CAN_NMAX: rd_next = {16'h0000, can_sensor_neutral_max_reg};
            `STACAL_OFF_CAN_SPAN: rd_next = {16'h0000, can_sensor_min_span_reg};
            `STACAL_OFF_CAN_NMIN: rd_next = {16'h0000, can_sensor_neutral_min_reg};
            `STACAL_OFF_ANA_NMAX: rd_next = {16'h0000, analog_neutral_max_reg};
            `STACAL_OFF_ANA_SPAN: rd_next = {16'h0000, analog_min_span_reg};
            `STACAL_OFF_ANA_NMIN: rd_next = {16'h0000, analog_neutral_min_reg};
            `STACAL_OFF_DB_MAX: rd_next = {16'h0000, deadband_limit_max_reg};
            `STACAL_OFF_DB_MIN: rd_next = {16'h0000, deadband_limit_min_reg};
            `STACAL_OFF_ACT_TMO: rd_next = {24'h000000, activation_timeout_reg};
            `STACAL_OFF_INIT_SP: rd_next = {16'h0000, initial_spool_setpoint_reg};
            `STACAL_OFF_STATUS: rd_next = {16'h0000, 4'h0, right_done, left_done, span_error,
                                           neutral_error, status_byte4};
            `STACAL_OFF_DEADBAND: rd_next = {left_deadband_value, right_deadband_value};
            `STACAL_OFF_SETPOINT: rd_next = {16'h0000, spool_setpoint};
            default: bad_addr = 1'b1;
        endcase
    end

    // slave answers one cycle after setup: pready rises in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
            if (rd_en) begin
                prdata <= rd_next;
            end
        end
    end

    // configuration registers; status offsets are read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sweep_half_range_reg <= `STACAL_RST_SWEEP_HALF;
            max_sweep_time_reg <= `STACAL_RST_MAX_TIME;
            min_sweep_time_reg <= `STACAL_RST_MIN_TIME;
            attempt_vector_size_reg <= `STACAL_RST_VEC_SIZE;
            min_equal_attempts_reg <= `STACAL_RST_MIN_EQUAL;
            sweep_addon_range_reg <= `STACAL_RST_SWEEP_ADDON;
            setpoint_step_percent_reg <= `STACAL_RST_STEP_PCT;
            can_sensor_neutral_max_reg <= `STACAL_RST_CAN_NMAX;
            can_sensor_min_span_reg <= `STACAL_RST_CAN_SPAN;
            can_sensor_neutral_min_reg <= `STACAL_RST_CAN_NMIN;
            analog_neutral_max_reg <= `STACAL_RST_ANA_NMAX;
            analog_min_span_reg <= `STACAL_RST_ANA_SPAN;
            analog_neutral_min_reg <= `STACAL_RST_ANA_NMIN;
            deadband_limit_max_reg <= `STACAL_RST_DB_MAX;
            deadband_limit_min_reg <= `STACAL_RST_DB_MIN;
            activation_timeout_reg <= `STACAL_RST_ACT_TMO;
            initial_spool_setpoint_reg <= `STACAL_RST_INIT_SP;
        end else if (wr_en) begin
            case (paddr)
                `STACAL_OFF_SWEEP_HALF: sweep_half_range_reg <= pwdata[15:0];
                `STACAL_OFF_MAX_TIME: max_sweep_time_reg <= pwdata[15:0];
                `STACAL_OFF_MIN_TIME: min_sweep_time_reg <= pwdata[15:0];
                `STACAL_OFF_VEC_SIZE: attempt_vector_size_reg <= pwdata[7:0];
                `STACAL_OFF_MIN_EQUAL: min_equal_attempts_reg <= pwdata[7:0];
                `STACAL_OFF_SWEEP_ADDON: sweep_addon_range_reg <= pwdata[15:0];
                `STACAL_OFF_STEP_PCT: setpoint_step_percent_reg <= pwdata[7:0];
                `STACAL_OFF_CAN_NMAX: can_sensor_neutral_max_reg <= pwdata[15:0];
                `STACAL_OFF_CAN_SPAN: can_sensor_min_span_reg <= pwdata[15:0];
                `STACAL_OFF_CAN_NMIN: can_sensor_neutral_min_reg <= pwdata[15:0];
                `STACAL_OFF_ANA_NMAX: analog_neutral_max_reg <= pwdata[15:0];
                `STACAL_OFF_ANA_SPAN: analog_min_span_reg <= pwdata[15:0];
                `STACAL_OFF_ANA_NMIN: analog_neutral_min_reg <= pwdata[15:0];
                `STACAL_OFF_DB_MAX: deadband_limit_max_reg <= pwdata[15:0];
                `STACAL_OFF_DB_MIN: deadband_limit_min_reg <= pwdata[15:0];
                `STACAL_OFF_ACT_TMO: activation_timeout_reg <= pwdata[7:0];
                `STACAL_OFF_INIT_SP: initial_spool_setpoint_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // capture plausibility, unsigned millivolts throughout
    logic [15:0] nmax, nmin, span;
    logic neutral_ok, span_ok;
    logic [15:0] hi_val, lo_val;
    always_comb begin
        nmax = capture_is_can ? can_sensor_neutral_max_reg : analog_neutral_max_reg;
        nmin = capture_is_can ? can_sensor_neutral_min_reg : analog_neutral_min_reg;
        span = capture_is_can ? can_sensor_min_span_reg : analog_min_span_reg;
        neutral_ok = (capture.neutral > nmin) && (capture.neutral < nmax);
        // decide which side reads higher before taking differences
        hi_val = (capture.right >= capture.left) ? capture.right : capture.left;
        lo_val = (capture.right >= capture.left) ? capture.left : capture.right;
        // 17-bit compare so a neutral beyond an end never wraps into a pass
        span_ok = ({1'b0, hi_val} >= {1'b0, capture.neutral} + {1'b0, span}) &&
                  ({1'b0, capture.neutral} >= {1'b0, lo_val} + {1'b0, span});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_done <= 1'b0;
            neutral_error <= 1'b0;
            span_error <= 1'b0;
        end else begin
            capture_done <= capture_valid;
            if (capture_valid) begin
                neutral_error <= !neutral_ok;
                span_error <= !span_ok;
            end
        end
    end

    // attempt classification and set-point stepping
    logic too_slow, too_fast, edge_ok;
    logic signed [16:0] edge_s, lim_max_s, lim_min_s;
    logic [31:0] step_amt;
    always_comb begin
        too_slow = attempt.sweep_time > max_sweep_time_reg;
        too_fast = attempt.sweep_time < min_sweep_time_reg;
        edge_s = {attempt.db_edge[15], attempt.db_edge};
        lim_max_s = {1'b0, deadband_limit_max_reg};
        lim_min_s = {1'b0, deadband_limit_min_reg};
        if (attempt.side_left) begin
            edge_ok = (edge_s >= -lim_max_s) && (edge_s <= -lim_min_s);
        end else begin
            edge_ok = (edge_s >= lim_min_s) && (edge_s <= lim_max_s);
        end
        step_amt = (32'(spool_setpoint) * 32'(setpoint_step_percent_reg)) / 32'd100;
    end

    // attempt vectors, one per side, newest at index 0
    logic [15:0] vec_l [`STACAL_VEC_MAX];
    logic [15:0] vec_r [`STACAL_VEC_MAX];
    logic [3:0] cnt_l, cnt_r;
    stacal_state_type state_reg, state_next;
    logic acc;
    assign acc = attempt_valid && calib_running && !too_slow && !too_fast && edge_ok;

    genvar gi;
    generate
        for (gi = 0; gi < `STACAL_VEC_MAX; gi++) begin : g_vec
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vec_l[gi] <= 16'h0000;
                    vec_r[gi] <= 16'h0000;
                end else if (acc) begin
                    // shifting drops the oldest entry once the vector is full
                    if (attempt.side_left) begin
                        vec_l[gi] <= (gi == 0) ? attempt.db_edge : vec_l[(gi == 0) ? 0 : gi - 1];
                    end else begin
                        vec_r[gi] <= (gi == 0) ? attempt.db_edge : vec_r[(gi == 0) ? 0 : gi - 1];
                    end
                end
            end
        end
    endgenerate

    // count equal entries inside the configured window for the new edge
    function automatic logic [3:0] count_eq(input logic side_left,
                                            input logic [3:0] fill, input logic [15:0] val);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < `STACAL_VEC_MAX - 1; i++) begin
            if (4'(i) < fill && (side_left ? vec_l[i] : vec_r[i]) == val) begin
                n = n + 4'h1;
            end
        end
        return n;
    endfunction

    logic [3:0] vsz, eq_new;
    always_comb begin
        vsz = (attempt_vector_size_reg > 8'h0A) ? 4'hA : attempt_vector_size_reg[3:0];
        // the incoming edge counts itself; window holds vsz-1 older entries
        eq_new = 4'h1 + count_eq(attempt.side_left,
                                 ((attempt.side_left ? cnt_l : cnt_r) < vsz ?
                                  (attempt.side_left ? cnt_l : cnt_r) : vsz - 4'h1), attempt.db_edge);
    end

    // fill levels, completion and stored dead-band values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_l <= 4'h0;
            cnt_r <= 4'h0;
            left_done <= 1'b0;
            right_done <= 1'b0;
            left_deadband_value <= 16'h0000;
            right_deadband_value <= 16'h0000;
        end else if (start_request && state_reg == STACAL_ARMED) begin
            cnt_l <= 4'h0;
            cnt_r <= 4'h0;
            left_done <= 1'b0;
            right_done <= 1'b0;
        end else if (acc) begin
            if (attempt.side_left) begin
                cnt_l <= (cnt_l < vsz) ? cnt_l + 4'h1 : vsz;
                if (!left_done && {4'h0, eq_new} >= min_equal_attempts_reg) begin
                    left_done <= 1'b1;
                    left_deadband_value <= attempt.db_edge;
                end
            end else begin
                cnt_r <= (cnt_r < vsz) ? cnt_r + 4'h1 : vsz;
                if (!right_done && {4'h0, eq_new} >= min_equal_attempts_reg) begin
                    right_done <= 1'b1;
                    right_deadband_value <= attempt.db_edge;
                end
            end
        end
    end

    // set-point: loaded at start, stepped by percent after slow or fast sweeps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spool_setpoint <= `STACAL_RST_INIT_SP;
        end else if (start_request && state_reg == STACAL_ARMED) begin
            spool_setpoint <= initial_spool_setpoint_reg;
        end else if (attempt_valid && calib_running) begin
            if (too_slow) begin
                spool_setpoint <= spool_setpoint + step_amt[15:0];
            end else if (too_fast) begin
                spool_setpoint <= spool_setpoint - step_amt[15:0];
            end
        end
    end

    // arming state machine and the seconds counter of the start window
    logic [26:0] tick_reg;
    logic [7:0] secs_reg;
    logic timed_out;
    assign timed_out = secs_reg >= activation_timeout_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            STACAL_IDLE: if (steering_active) state_next = STACAL_ARMING;
            STACAL_ARMING: if (!steering_active) state_next = STACAL_ARMED;
            STACAL_ARMED: begin
                if (steering_active) begin
                    state_next = STACAL_ARMING;
                end else if (start_request) begin
                    state_next = STACAL_RUN;
                end else if (timed_out) begin
                    state_next = STACAL_IDLE;
                end
            end
            STACAL_RUN: if (wheel_grab || (left_done && right_done)) state_next = STACAL_IDLE;
            default: state_next = STACAL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= STACAL_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= 27'h0000000;
            secs_reg <= 8'h00;
        end else if (state_reg != STACAL_ARMED) begin
            tick_reg <= 27'h0000000;
            secs_reg <= 8'h00;
        end else if (tick_reg == 27'(SECOND_CYCLES - 1)) begin
            tick_reg <= 27'h0000000;
            secs_reg <= secs_reg + 8'h01;
        end else begin
            tick_reg <= tick_reg + 27'h0000001;
        end
    end

    // status code for byte 4 of the operation status message
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_byte4 <= `STACAL_CODE_INACTIVE;
            calib_running <= 1'b0;
        end else begin
            calib_running <= state_next == STACAL_RUN;
            case (state_next)
                STACAL_IDLE: status_byte4 <= `STACAL_CODE_INACTIVE;
                STACAL_ARMING: status_byte4 <= `STACAL_CODE_ARMING;
                STACAL_ARMED: status_byte4 <= `STACAL_CODE_ARMED;
                default: status_byte4 <= `STACAL_CODE_RUNNING;
            endcase
        end
    end

    sequence s_armed_req;
        state_reg == STACAL_ARMED && !steering_active && start_request && !timed_out;
    endsequence

    AST_START_FROM_ARMED: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(calib_running) |-> $past(state_reg) == STACAL_ARMED)
        else $error("calibration started without arming");
    AST_ARMED_START: assert property (@(posedge pclk) disable iff (!presetn)
        s_armed_req |=> calib_running && status_byte4 == `STACAL_CODE_RUNNING)
        else $error("start request in window ignored");
    AST_GRAB_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == STACAL_RUN && wheel_grab |=> !calib_running && status_byte4 == `STACAL_CODE_INACTIVE)
        else $error("grab did not disengage");
    AST_ARMING_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == STACAL_IDLE && steering_active |=> status_byte4 == `STACAL_CODE_ARMING)
        else $error("arming code missing");
    AST_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == STACAL_ARMED && timed_out && !start_request && !steering_active
        |=> status_byte4 == `STACAL_CODE_INACTIVE)
        else $error("window did not close");
    AST_NEUTRAL: assert property (@(posedge pclk) disable iff (!presetn)
        capture_valid |=> neutral_error == !$past(neutral_ok) && capture_done)
        else $error("neutral error wrong");
    AST_SPAN: assert property (@(posedge pclk) disable iff (!presetn)
        capture_valid && capture.left == capture.neutral && span != 16'h0000 |=> span_error)
        else $error("span error missed");
    AST_SLOW_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        attempt_valid && calib_running && too_slow
        |=> spool_setpoint == $past(spool_setpoint) + $past(step_amt[15:0]))
        else $error("slow step wrong");
    AST_FAST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        attempt_valid && calib_running && too_fast && !too_slow
        |=> spool_setpoint == $past(spool_setpoint) - $past(step_amt[15:0]))
        else $error("fast step wrong");
    AST_RIGHT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(right_done) |-> $signed(right_deadband_value) >= $signed({1'b0, deadband_limit_min_reg}))
        else $error("right edge below limit");
endmodule

// ---- testbench/stacal_host_model.sv ----
`timescale 1ns/1ps
// host side: steers the wheel, asks for a start or grabs the wheel on command
module stacal_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] cmd,
    output logic steering_active,
    output logic start_request,
    output logic wheel_grab
);
    // levels follow the command one edge later, as a real operator would lag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steering_active <= 1'b0;
            start_request <= 1'b0;
            wheel_grab <= 1'b0;
        end else begin
            steering_active <= cmd == 2'h1;
            start_request <= cmd == 2'h2;
            wheel_grab <= cmd == 2'h3;
        end
    end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("Error at %0t: %h vs %h", $time, a, b); end end
module tb;
    import stacal_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, capture_valid = 1'b0, capture_is_can = 1'b0, capture_done, neutral_error, span_error;
    stacal_capture_type capture = '0;
    logic attempt_valid = 1'b0, left_done, right_done, steering_active, wheel_grab, start_request, calib_running;
    stacal_attempt_type attempt = '0;
    logic [15:0] left_deadband_value, right_deadband_value, spool_setpoint;
    logic [7:0] status_byte4;
    logic [1:0] cmd = 2'h0;
    int failures = 0, checked = 0;
    logic [15:0] rst_tab [10] = '{16'h19, 16'h6E, 16'h3C, 16'h7, 16'h5, 16'h19, 16'hA, 16'h1194, 16'h0, 16'h1F4};
    // one second shrunk to ten cycles so the start window closes quickly
    stacal_checker #(.SECOND_CYCLES(10)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .capture_valid, .capture_is_can, .capture, .capture_done, .neutral_error,
        .span_error, .attempt_valid, .attempt, .left_deadband_value, .right_deadband_value, .left_done,
        .right_done, .spool_setpoint, .steering_active, .wheel_grab, .start_request, .calib_running, .status_byte4);
    stacal_host_model host_u (.pclk, .presetn, .cmd, .steering_active, .start_request, .wheel_grab);
    initial begin
        forever #4 pclk = ~pclk;
    end
    // one apb transfer; waits for pready however long the slave takes
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task cap(input logic can, input logic [15:0] l, r, n, input logic ne, se);
        @(posedge pclk);
        {capture_valid, capture_is_can, capture} <= {1'b1, can, l, r, n};
        @(posedge pclk);
        capture_valid <= 1'b0;
        @(negedge pclk);
        `CHK({capture_done, neutral_error, span_error}, {1'b1, ne, se})
    endtask
    task att(input logic s, input logic [15:0] t, e);
        @(posedge pclk);
        {attempt_valid, attempt} <= {1'b1, s, t, e};
        @(posedge pclk);
        attempt_valid <= 1'b0;
        @(negedge pclk);
    endtask
    // host command, then settle for n cycles before looking at status
    task go(input logic [1:0] c, input int n, input logic [7:0] st);
        @(posedge pclk);
        cmd <= c;
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        `CHK(status_byte4, st)
    endtask
    task end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            `CHK(rd, {16'h0, rst_tab[i]})
        end
        apb(1'b0, 12'h050, 32'h0);
        `CHK({perr, rd}, {1'b1, 32'h0})
        go(2'h2, 3, 8'h21);
        cap(1'b0, 16'h0100, 16'h1000, 16'h01F4, 1'b1, 1'b0);
        cap(1'b0, 16'h0100, 16'h1000, 16'h01F5, 1'b0, 1'b0);
        apb(1'b1, 12'h02C, 32'h100);
        cap(1'b0, 16'h0100, 16'h1000, 16'h01F5, 1'b0, 1'b1);
        cap(1'b0, 16'h1000, 16'h0100, 16'h0200, 1'b0, 1'b0);
        cap(1'b1, 16'h1100, 16'h1200, 16'h1194, 1'b1, 1'b0);
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h040, 32'h73);
        go(2'h1, 3, 8'h22);
        go(2'h0, 3, 8'h23);
        go(2'h2, 3, 8'h24);
        att(1'b0, 16'h0100, 16'h0000);
        `CHK({calib_running, spool_setpoint}, {1'b1, 16'h007E})
        att(1'b0, 16'h0010, 16'h0000);
        `CHK({calib_running, spool_setpoint}, {1'b1, 16'h0072})
        go(2'h3, 3, 8'h21);
        go(2'h1, 3, 8'h22);
        go(2'h0, 3, 8'h23);
        go(2'h2, 3, 8'h24);
        att(1'b0, 16'h0050, 16'h012C);
        `CHK({right_done, right_deadband_value}, {1'b1, 16'h012C})
        att(1'b1, 16'h0050, 16'hFED4);
        `CHK({left_done, left_deadband_value}, {1'b1, 16'hFED4})
        go(2'h0, 3, 8'h21);
        go(2'h1, 3, 8'h22);
        go(2'h0, 180, 8'h23);
        go(2'h0, 50, 8'h21);
        end_of_test();
    end
endmodule
